// *** src/epic_ctrl.sv ***
/*
 * Eight-level priority interrupt controller with two host I/O ports
 * (command/status and mask/init), nesting and rotating priority, special
 * mask mode, end-of-service commands and a three-byte call sequence.
 * Assumes the host bus is synchronous to clk and ioRd/ioWr/intAck are
 * one-cycle strobes; request inputs are asynchronous pins.
 */
`timescale 1ns/10ps
`default_nettype none

module epic_ctrl
    import epic_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic [7:0] ioAddr,
    input wire logic ioWr,
    input wire logic ioRd,
    input wire logic [7:0] ioWrData,
    output logic [7:0] ioRdData,
    input wire logic [7:0] requestPins,
    input wire logic intAck,
    output logic [7:0] ackData,
    output logic cpuInterruptLine
);
    import epic_pkg::*;

    // *****************************************************************
    // state
    // *****************************************************************
    epic_init_t initState_r, initState_nxt;
    epic_ack_t ackState_r;
    logic [7:0] pendingRequestReg_r;
    logic [7:0] inServiceReg_r;
    logic [7:0] perLevelMaskBits_r;
    logic [7:0] baseLow_r;
    logic [7:0] baseHigh_r;
    logic edgeMode_r;
    logic interval8_r;
    logic autoRotate_r;
    logic specialMask_r;
    logic readServ_r;
    logic [2:0] bottom_r;
    logic [7:0] reqPrev_r;
    logic [2:0] ackLevel_r;
    logic [7:0] ackData_r;
    logic [7:0] ioRdData_r;
    logic intLine_r;

    logic [7:0] reqSync;
    logic hit;
    logic [2:0] winner;
    logic servHit;
    logic [2:0] servTop;

    // *****************************************************************
    // pins and priority
    // *****************************************************************
    epic_sync #(.WIDTH(8)) uSync (
        .clk(clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .asyncIn(requestPins),
        .syncOut(reqSync)
    );

    epic_resolver uRes (
        .pending(pendingRequestReg_r),
        .inService(inServiceReg_r),
        .mask(perLevelMaskBits_r),
        .bottom(bottom_r),
        .specialMask(specialMask_r),
        .hit(hit),
        .winner(winner),
        .servHit(servHit),
        .servTop(servTop)
    );

    // *****************************************************************
    // port decode
    // *****************************************************************
    wire logic cmdSel = (ioAddr == EPIC_CMD_PORT);
    wire logic maskSel = (ioAddr == EPIC_MASK_PORT);
    wire logic cmdWr = clkEn && ioWr && cmdSel;
    wire logic maskWr = clkEn && ioWr && maskSel;
    wire logic ready = (initState_r == EPIC_INIT_DONE);
    wire logic isInitOne = cmdWr && ioWrData[EPIC_IW1_ID_BIT];
    wire logic opCmd = cmdWr && !isInitOne && ready;
    wire logic isNsEoi = opCmd && (ioWrData == EPIC_CMD_NS_EOI);
    wire logic isRotEoi = opCmd && (ioWrData == EPIC_CMD_ROTATE_EOI);
    wire logic isSpecEoi = opCmd && (ioWrData[7:3] == EPIC_CMD_SPEC_EOI);
    wire logic isRotSpec = opCmd && (ioWrData[7:3] == EPIC_CMD_ROT_SPEC_EOI);
    wire logic isSetBottom = opCmd && (ioWrData[7:3] == EPIC_CMD_SET_BOTTOM);
    wire logic [2:0] lvlSel = ioWrData[2:0];
    wire logic anyEoi = isNsEoi || isRotEoi;

    // nonspecific end-of-service takes the highest level in service; specific names it
    wire logic [7:0] nsClear = (anyEoi && servHit) ? (8'h01 << servTop) : 8'h00;
    wire logic [7:0] spClear = (isSpecEoi || isRotSpec) ? (8'h01 << lvlSel) : 8'h00;

    // rising edges seen after the two sync stages
    wire logic [7:0] riseEdge = reqSync & ~reqPrev_r;
    wire logic ackStart = clkEn && intAck && ackState_r == EPIC_ACK_CALL && intLine_r;
    wire logic [7:0] ackSet = ackStart ? (8'h01 << winner) : 8'h00;

    // level mode follows the pin; edge mode latches until acknowledged
    wire logic [7:0] pendNxt = edgeMode_r ? ((pendingRequestReg_r & ~(edgeMode_r ? ackSet : 8'h00)) | riseEdge)
                                          : reqSync;

    // vector low byte: level number inserted per interval
    wire logic [7:0] vecLow = interval8_r ? {baseLow_r[7:6], ackLevel_r, 3'h0}
                                          : {baseLow_r[7:5], ackLevel_r, 2'h0};

    // *****************************************************************
    // init sequencing
    // *****************************************************************
    always_comb begin
        initState_nxt = initState_r;
        case (initState_r)
            EPIC_INIT_IDLE, EPIC_INIT_DONE: begin
                if (isInitOne) begin
                    initState_nxt = EPIC_INIT_WAIT2;
                end
            end
            EPIC_INIT_WAIT2: begin
                if (isInitOne) begin
                    initState_nxt = EPIC_INIT_WAIT2;
                end else if (maskWr) begin
                    initState_nxt = EPIC_INIT_DONE;
                end
            end
            default: begin
                initState_nxt = EPIC_INIT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            initState_r <= EPIC_INIT_IDLE;
            edgeMode_r <= 1'b0;
            interval8_r <= 1'b0;
            baseLow_r <= 8'h00;
            baseHigh_r <= 8'h00;
        end else if (clkEn) begin
            initState_r <= initState_nxt;
            if (isInitOne) begin
                edgeMode_r <= ioWrData[EPIC_IW1_EDGE_BIT];
                interval8_r <= !ioWrData[EPIC_IW1_INT8_BIT];
                baseLow_r <= {ioWrData[7:5], 5'h00};
            end
            if (maskWr && initState_r == EPIC_INIT_WAIT2 && !isInitOne) begin
                baseHigh_r <= ioWrData;
            end
        end
    end

    // *****************************************************************
    // priority mode, mask, read select
    // *****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            perLevelMaskBits_r <= EPIC_MASK_RESET;
            autoRotate_r <= 1'b0;
            specialMask_r <= 1'b0;
            readServ_r <= 1'b0;
            bottom_r <= EPIC_BOTTOM_RESET;
        end else if (clkEn) begin
            if (isInitOne) begin
                // re-init returns to plain nesting with everything open
                perLevelMaskBits_r <= 8'h00;
                autoRotate_r <= 1'b0;
                specialMask_r <= 1'b0;
                readServ_r <= 1'b0;
                bottom_r <= EPIC_BOTTOM_RESET;
            end else begin
                if (maskWr && ready) begin
                    perLevelMaskBits_r <= ioWrData;
                end
                if (isRotEoi) begin
                    autoRotate_r <= 1'b1;
                end else if (isNsEoi || isSetBottom || isRotSpec || isSpecEoi) begin
                    autoRotate_r <= 1'b0;
                end
                if (isRotEoi && servHit) begin
                    bottom_r <= servTop;
                end else if (isNsEoi && autoRotate_r && servHit) begin
                    bottom_r <= servTop;
                end else if (isSetBottom || isRotSpec) begin
                    bottom_r <= lvlSel;
                end
                if (opCmd && ioWrData == EPIC_CMD_SMM_SET) begin
                    specialMask_r <= 1'b1;
                end else if (opCmd && ioWrData == EPIC_CMD_SMM_CLR) begin
                    specialMask_r <= 1'b0;
                end
                if (opCmd && ioWrData == EPIC_CMD_READ_PEND) begin
                    readServ_r <= 1'b0;
                end else if (opCmd && ioWrData == EPIC_CMD_READ_SERV) begin
                    readServ_r <= 1'b1;
                end
            end
        end
    end

    // *****************************************************************
    // pending and in-service registers
    // *****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pendingRequestReg_r <= 8'h00;
            reqPrev_r <= 8'h00;
            inServiceReg_r <= 8'h00;
        end else if (clkEn) begin
            reqPrev_r <= reqSync;
            pendingRequestReg_r <= pendNxt;
            if (isInitOne) begin
                inServiceReg_r <= 8'h00;
            end else begin
                // acknowledge set wins over a clear landing in the same cycle
                inServiceReg_r <= (inServiceReg_r & ~nsClear & ~spClear) | ackSet;
            end
        end
    end

    // *****************************************************************
    // interrupt line and acknowledge sequence
    // *****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            intLine_r <= 1'b0;
            ackState_r <= EPIC_ACK_CALL;
            ackLevel_r <= 3'h0;
            ackData_r <= 8'h00;
        end else if (clkEn) begin
            if (ackStart) begin
                intLine_r <= 1'b0;
            end else if (ready && hit) begin
                intLine_r <= 1'b1;
            end
            if (intAck) begin
                case (ackState_r)
                    EPIC_ACK_CALL: begin
                        ackData_r <= EPIC_CALL_OPCODE;
                        ackLevel_r <= winner;
                        ackState_r <= EPIC_ACK_LOW;
                    end
                    EPIC_ACK_LOW: begin
                        ackData_r <= vecLow;
                        ackState_r <= EPIC_ACK_HIGH;
                    end
                    EPIC_ACK_HIGH: begin
                        ackData_r <= baseHigh_r;
                        ackState_r <= EPIC_ACK_CALL;
                    end
                    default: begin
                        ackState_r <= EPIC_ACK_CALL;
                    end
                endcase
            end
        end
    end

    // *****************************************************************
    // read data
    // *****************************************************************
    wire logic [7:0] statusByte = readServ_r ? inServiceReg_r : pendingRequestReg_r;
    wire logic [7:0] rdMux = maskSel ? perLevelMaskBits_r : (cmdSel ? statusByte : 8'h00);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ioRdData_r <= 8'h00;
        end else if (clkEn && ioRd) begin
            ioRdData_r <= rdMux;
        end
    end

    assign ioRdData = ioRdData_r;
    assign ackData = ackData_r;
    assign cpuInterruptLine = intLine_r;
endmodule
`default_nettype wire

// *** src/epic_pkg.sv ***
/*
 * Package for the eight-level priority interrupt controller: port addresses,
 * command codes, init word field positions and the call opcode.
 * Assumes a byte-wide host I/O bus with an 8-bit port address.
 */
package epic_pkg;
    // *****************************************************************
    // port addresses
    // *****************************************************************
    localparam logic [7:0] EPIC_CMD_PORT = 8'hd8;
    localparam logic [7:0] EPIC_MASK_PORT = 8'hd9;

    // *****************************************************************
    // command codes
    // *****************************************************************
    localparam logic [7:0] EPIC_CMD_ROTATE_EOI = 8'ha0;
    localparam logic [7:0] EPIC_CMD_NS_EOI = 8'h20;
    localparam logic [4:0] EPIC_CMD_SPEC_EOI = 5'h0c;
    localparam logic [4:0] EPIC_CMD_SET_BOTTOM = 5'h18;
    localparam logic [4:0] EPIC_CMD_ROT_SPEC_EOI = 5'h1c;
    localparam logic [7:0] EPIC_CMD_READ_PEND = 8'h0a;
    localparam logic [7:0] EPIC_CMD_READ_SERV = 8'h0b;
    localparam logic [7:0] EPIC_CMD_SMM_SET = 8'h68;
    localparam logic [7:0] EPIC_CMD_SMM_CLR = 8'h48;

    // *****************************************************************
    // init word one fields
    // *****************************************************************
    localparam int EPIC_IW1_ID_BIT = 4;
    localparam int EPIC_IW1_EDGE_BIT = 3;
    localparam int EPIC_IW1_INT8_BIT = 2;
    localparam int EPIC_IW1_SINGLE_BIT = 1;

    // *****************************************************************
    // acknowledge sequence and reset values
    // *****************************************************************
    localparam logic [7:0] EPIC_CALL_OPCODE = 8'hcd;
    localparam logic [7:0] EPIC_MASK_RESET = 8'hff;
    localparam logic [2:0] EPIC_BOTTOM_RESET = 3'h7;

    typedef enum {EPIC_INIT_IDLE, EPIC_INIT_WAIT2, EPIC_INIT_DONE} epic_init_t;
    typedef enum {EPIC_ACK_CALL, EPIC_ACK_LOW, EPIC_ACK_HIGH} epic_ack_t;
endpackage

// *** src/epic_sync.sv ***
/*
 * Two-flop synchroniser for a vector of asynchronous pins.
 * Assumes the sampled inputs may change at any time relative to clk.
 */
`timescale 1ns/10ps
`default_nettype none
module epic_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stage1_r <= '0;
            stage2_r <= '0;
        end else if (clkEn) begin
            stage1_r <= asyncIn;
            stage2_r <= stage1_r;
        end
    end

    assign syncOut = stage2_r;
endmodule
`default_nettype wire

// *** src/epic_resolver.sv ***
/*
 * Priority resolver: finds the best unmasked request that outranks every
 * level in service (only unmasked ones in special mask mode), under a rotating bottom-priority level.
 * Assumes bottom = 7 gives the fixed order, level 0 highest.
 */
`timescale 1ns/10ps
`default_nettype none
module epic_resolver (
    input wire logic [7:0] pending,
    input wire logic [7:0] inService,
    input wire logic [7:0] mask,
    input wire logic [2:0] bottom,
    input wire logic specialMask,
    output logic hit,
    output logic [2:0] winner,
    output logic servHit,
    output logic [2:0] servTop
);
    // scan from the level after bottom; first set bit wins
    function automatic logic [3:0] first_set(input logic [7:0] v, input logic [2:0] bot);
        logic [3:0] res;
        logic [2:0] lvl;
        res = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            lvl = 3'(bot + 3'(i) + 3'h1);
            if (v[lvl]) begin
                res = {1'b1, lvl};
            end
        end
        return res;
    endfunction

    wire logic [7:0] request = pending & ~mask;
    // special mask hides masked in-service levels from the nesting check
    wire logic [7:0] blocking = specialMask ? (inService & ~mask) : inService;
    wire logic [3:0] reqTop = first_set(request, bottom);
    wire logic [3:0] blkTop = first_set(blocking, bottom);
    wire logic [3:0] isTop = first_set(inService, bottom);
    // rank distance from the highest-priority slot
    wire logic [2:0] reqRank = 3'(reqTop[2:0] - bottom - 3'h1);
    wire logic [2:0] blkRank = 3'(blkTop[2:0] - bottom - 3'h1);

    assign hit = reqTop[3] && (!blkTop[3] || reqRank < blkRank);
    assign winner = reqTop[2:0];
    assign servHit = isTop[3];
    assign servTop = isTop[2:0];
endmodule
`default_nettype wire

// *** dv/epic_ctrl_monitor.sv ***
/*
 * Port checker for epic_ctrl, bound to every instance.
 * Assumes clkEn high during checked traffic and one-cycle bus strobes.
 */
`timescale 1ns/10ps
`default_nettype none
module epic_ctrl_monitor
    import epic_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic [7:0] ioAddr,
    input wire logic ioWr,
    input wire logic ioRd,
    input wire logic [7:0] ioWrData,
    input wire logic [7:0] ioRdData,
    input wire logic [7:0] requestPins,
    input wire logic intAck,
    input wire logic [7:0] ackData,
    input wire logic cpuInterruptLine
);
    // ****************************************
    // init tracking
    // ****************************************
    logic [1:0] initStep_r;
    wire logic wrTaken = clkEn && ioWr;
    wire logic iw1Seen = wrTaken && ioAddr == EPIC_CMD_PORT && ioWrData[EPIC_IW1_ID_BIT];
    wire logic iw2Seen = wrTaken && ioAddr == EPIC_MASK_PORT && initStep_r == 2'h1;
    wire logic [1:0] initStep_nxt = iw1Seen ? 2'h1 : (iw2Seen ? 2'h2 : initStep_r);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            initStep_r <= 2'h0;
        end else begin
            initStep_r <= initStep_nxt;
        end
    end

    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_call_opcode: assert property (intAck && cpuInterruptLine |=> ackData == EPIC_CALL_OPCODE)
        else $error("call opcode missing after acknowledge");
    a_line_drop: assert property (intAck && cpuInterruptLine |=> !cpuInterruptLine)
        else $error("interrupt line not cleared by acknowledge");
    // pins must be quiet long enough that no change is still in the synchronisers
    a_line_holds: assert property (($stable(requestPins) [*6]) ##0
        (cpuInterruptLine && !intAck && !$past(ioWr)) |=> cpuInterruptLine)
        else $error("interrupt line dropped before acknowledge");
    a_unmapped_read: assert property (ioRd && clkEn && ioAddr != EPIC_CMD_PORT
        && ioAddr != EPIC_MASK_PORT |=> ioRdData == 8'h00)
        else $error("unmapped read returned data");
    a_read_hold: assert property (!(ioRd && clkEn) |=> $stable(ioRdData))
        else $error("read data changed without a read");
    a_ack_hold: assert property (!(intAck && clkEn) |=> $stable(ackData))
        else $error("acknowledge byte changed without acknowledge");
    a_quiet_pre_init: assert property (initStep_r != 2'h2 |-> !cpuInterruptLine)
        else $error("interrupt raised before init completed");
    a_mask_readback: assert property ((ioWr && ioAddr == EPIC_MASK_PORT && initStep_r == 2'h2) ##2
        (ioRd && ioAddr == EPIC_MASK_PORT) |=> ioRdData == $past(ioWrData, 3))
        else $error("mask read differs from last mask write");
endmodule

bind epic_ctrl epic_ctrl_monitor u_epic_ctrl_monitor (.clk(clk), .rst_b(rst_b), .clkEn(clkEn),
    .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd), .ioWrData(ioWrData), .ioRdData(ioRdData),
    .requestPins(requestPins), .intAck(intAck), .ackData(ackData), .cpuInterruptLine(cpuInterruptLine));
`default_nettype wire

// *** dv/epic_host_model.sv ***
/*
 * Host processor model: byte-wide port writes, reads and acknowledge pulses.
 * Assumes the controller answers one cycle after each taken strobe.
 */
`timescale 1ns/10ps
`default_nettype none
module epic_host_model
    import epic_pkg::*;
(
    input wire logic clk,
    output logic [7:0] ioAddr,
    output logic ioWr,
    output logic ioRd,
    output logic [7:0] ioWrData,
    input wire logic [7:0] ioRdData,
    output logic intAck,
    input wire logic [7:0] ackData
);
    // ****************************************
    // bus cycles
    // ****************************************
    initial begin
        ioAddr = 8'h00;
        ioWr = 1'b0;
        ioRd = 1'b0;
        ioWrData = 8'h00;
        intAck = 1'b0;
    end
    // a released bus never keeps its last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        ioAddr <= a;
        ioWrData <= d;
        ioWr <= 1'b1;
        @(posedge clk);
        ioWr <= 1'b0;
        ioAddr <= ~a;
        ioWrData <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        ioAddr <= a;
        ioRd <= 1'b1;
        @(posedge clk);
        ioRd <= 1'b0;
        ioAddr <= ~a;
        @(posedge clk);
        #1;
        d = ioRdData;
    endtask
    task automatic ack(output logic [7:0] d);
        @(posedge clk);
        intAck <= 1'b1;
        @(posedge clk);
        intAck <= 1'b0;
        @(posedge clk);
        #1;
        d = ackData;
    endtask
    // host keeps its own acceptance off, so no acknowledge runs between the words
    task automatic init(input logic [7:0] w1, input logic [7:0] w2);
        wr(EPIC_CMD_PORT, w1);
        wr(EPIC_MASK_PORT, w2);
    endtask
endmodule
`default_nettype wire

// *** dv/eight_level_priority_interrupt_ctrl_tb_top.sv ***
/*
 * Self-checking bench for epic_ctrl driven through the host model.
 * Assumes a 200 MHz clock and synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module eight_level_priority_interrupt_ctrl_tb_top;
    import epic_pkg::*;
    logic clk = 1'b0;
    logic rst_b;
    logic [7:0] requestPins;
    logic [7:0] ioAddr, ioWrData, ioRdData, ackData, iw1, iw2, b, p;
    logic ioWr, ioRd, intAck, cpuInterruptLine;
    int errors, compares, seedDummy;
    always #2.5 clk = ~clk;
    epic_ctrl u_epic_ctrl (.clk(clk), .rst_b(rst_b), .clkEn(1'b1), .ioAddr(ioAddr), .ioWr(ioWr),
        .ioRd(ioRd), .ioWrData(ioWrData), .ioRdData(ioRdData), .requestPins(requestPins),
        .intAck(intAck), .ackData(ackData), .cpuInterruptLine(cpuInterruptLine));
    epic_host_model u_epic_host_model (.clk(clk), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd),
        .ioWrData(ioWrData), .ioRdData(ioRdData), .intAck(intAck), .ackData(ackData));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] lowByte(input logic [7:0] w, input logic [2:0] lvl);
        return w[EPIC_IW1_INT8_BIT] ? {w[7:5], lvl, 2'b00} : {w[7:6], lvl, 3'b000};
    endfunction
    function automatic logic [2:0] firstSet(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) firstSet = 3'(i);
        end
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic waitLine(input logic [7:0] lvl);
        for (int n = 0; n < 12 && {7'h0, cpuInterruptLine} !== lvl; n++) begin
            @(posedge clk);
            #1;
        end
        check({7'h0, cpuInterruptLine}, lvl);
    endtask
    task automatic setPins(input logic [7:0] v, input int settle);
        @(posedge clk);
        requestPins <= v;
        repeat (settle) @(posedge clk);
        #1;
    endtask
    task automatic serve(input logic [2:0] lvl);
        u_epic_host_model.ack(b);
        check(b, EPIC_CALL_OPCODE);
        u_epic_host_model.ack(b);
        check(b, lowByte(iw1, lvl));
        u_epic_host_model.ack(b);
        check(b, iw2);
    endtask
    task automatic readSel(input logic [7:0] cmd, input logic [7:0] exp);
        u_epic_host_model.wr(EPIC_CMD_PORT, cmd);
        u_epic_host_model.rd(EPIC_CMD_PORT, b);
        check(b, exp);
    endtask
    task automatic final_report;
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        final_report;
    end
    initial begin
        errors = 0;
        compares = 0;
        rst_b = 1'b0;
        requestPins = 8'h00;
        seedDummy = $urandom(32'hae03);
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        u_epic_host_model.rd(8'h33, b);
        check(b, 8'h00);
        u_epic_host_model.rd(EPIC_MASK_PORT, b);
        check(b, EPIC_MASK_RESET);
        iw1 = 8'h56;
        iw2 = 8'h40;
        u_epic_host_model.init(iw1, iw2);
        u_epic_host_model.rd(EPIC_MASK_PORT, b);
        check(b, 8'h00);
        for (int i = 0; i < 4; i++) begin
            p = 8'($urandom);
            u_epic_host_model.wr(EPIC_MASK_PORT, p);
            u_epic_host_model.rd(EPIC_MASK_PORT, b);
            check(b, p);
        end
        u_epic_host_model.wr(EPIC_MASK_PORT, 8'h00);
        for (int i = 0; i < 6; i++) begin
            p = 8'($urandom_range(255, 1));
            setPins(p, 1);
            waitLine(8'h01);
            serve(firstSet(p));
            readSel(EPIC_CMD_READ_SERV, 8'h01 << firstSet(p));
            readSel(EPIC_CMD_READ_PEND, p);
            check({7'h0, cpuInterruptLine}, 8'h00);
            // drop requests before the end: a standing level would raise the line again
            setPins(8'h00, 8);
            u_epic_host_model.wr(EPIC_CMD_PORT, EPIC_CMD_NS_EOI);
            readSel(EPIC_CMD_READ_SERV, 8'h00);
        end
        setPins(8'h08, 1);
        waitLine(8'h01);
        serve(3'h3);
        setPins(8'h09, 1);
        waitLine(8'h01);
        serve(3'h0);
        u_epic_host_model.wr(EPIC_CMD_PORT, {EPIC_CMD_SPEC_EOI, 3'h3});
        readSel(EPIC_CMD_READ_SERV, 8'h01);
        setPins(8'h00, 8);
        u_epic_host_model.wr(EPIC_CMD_PORT, EPIC_CMD_NS_EOI);
        u_epic_host_model.wr(EPIC_CMD_PORT, {EPIC_CMD_SET_BOTTOM, 3'h2});
        setPins(8'h11, 1);
        waitLine(8'h01);
        serve(3'h4);
        readSel(EPIC_CMD_READ_SERV, 8'h10);
        setPins(8'h00, 8);
        u_epic_host_model.wr(EPIC_CMD_PORT, {EPIC_CMD_SET_BOTTOM, 3'h7});
        u_epic_host_model.wr(EPIC_CMD_PORT, EPIC_CMD_NS_EOI);
        setPins(8'h04, 1);
        waitLine(8'h01);
        serve(3'h2);
        u_epic_host_model.wr(EPIC_MASK_PORT, 8'h04);
        setPins(8'h24, 8);
        check({7'h0, cpuInterruptLine}, 8'h00);
        u_epic_host_model.wr(EPIC_CMD_PORT, EPIC_CMD_SMM_SET);
        waitLine(8'h01);
        serve(3'h5);
        u_epic_host_model.wr(EPIC_CMD_PORT, EPIC_CMD_SMM_CLR);
        setPins(8'h00, 8);
        u_epic_host_model.wr(EPIC_CMD_PORT, {EPIC_CMD_SPEC_EOI, 3'h5});
        u_epic_host_model.wr(EPIC_CMD_PORT, {EPIC_CMD_SPEC_EOI, 3'h2});
        readSel(EPIC_CMD_READ_SERV, 8'h00);
        u_epic_host_model.wr(EPIC_MASK_PORT, 8'h00);
        u_epic_host_model.wr(EPIC_CMD_PORT, EPIC_CMD_ROTATE_EOI);
        setPins(8'h50, 1);
        waitLine(8'h01);
        serve(3'h4);
        u_epic_host_model.wr(EPIC_CMD_PORT, EPIC_CMD_NS_EOI);
        waitLine(8'h01);
        serve(3'h6);
        setPins(8'h00, 8);
        u_epic_host_model.wr(EPIC_CMD_PORT, EPIC_CMD_NS_EOI);
        iw1 = 8'h5a;
        u_epic_host_model.init(iw1, iw2);
        setPins(8'h02, 1);
        waitLine(8'h01);
        serve(3'h1);
        readSel(EPIC_CMD_READ_PEND, 8'h00);
        u_epic_host_model.wr(EPIC_CMD_PORT, EPIC_CMD_NS_EOI);
        setPins(8'h02, 8);
        check({7'h0, cpuInterruptLine}, 8'h00);
        final_report;
    end
endmodule
`default_nettype wire
